/* hw/instr_decode_regs.vh */
// Constants for the instruction word decoder and its register file
`ifndef INSTR_DECODE_REGS_VH
`define INSTR_DECODE_REGS_VH

// Instruction word and timing
`define IWORD_W          14
`define OSC_PER_ICYC     4
`define PHASE_LAST       2'h3

// Register offsets (byte addresses)
`define OFS_CTRL         12'h000
`define OFS_STAT         12'h004
`define OFS_RETIRED      12'h008
`define OFS_LASTWORD     12'h00c

// Register fields and reset values
`define CTRL_RUN_BIT     0
`define CTRL_RST_VAL     1'h1
`define STAT_BUSY_BIT    0
`define STAT_NOP_BIT     3

// Instruction classes
`define CLS_BYTE         2'h0
`define CLS_BIT          2'h1
`define CLS_LIT          2'h2

// Indirect file register addresses within a bank
`define INDF0_ADDR       7'h00
`define INDF1_ADDR       7'h01

// Opcode patterns
`define OP_ZERO_GRP      4'h0
`define OP_CLRW_HI       10'h040
`define OP_PTRMOVE_HI    8'h01
`define OP_RET_SUB       14'h0008
`define OP_RET_INT       14'h0009
`define OP_CALL_ACC      14'h000a
`define OP_BR_ACC        14'h000b
`define OP_RET_LIT_HI    4'h4
`define OP_BR_REL_HI     3'h1
`define OP_DEC_SKIP_HI   4'hb
`define OP_INC_SKIP_HI   4'hf
`define OP_BIT_CLR_SKIP  2'h2
`define OP_BIT_SET_SKIP  2'h3

`endif

/* hw/instr_word_decode_timing.v */
// Instruction word decoder with instruction cycle timing and APB registers
//
// Our own choices: the address map and the APB register port.
`timescale 1ns/1ns
`default_nettype none
`include "instr_decode_regs.vh"

// Functional notes
// - One 14-bit word holds opcode and operands
// - Sort opcodes into byte, bit, literal/control classes
// - Default instruction lasts one instruction cycle
// - Both subroutine calls take two cycles
// - All three returns take two cycles
// - Jumps, branches, taken skips take two cycles
// - Indirect access to program memory adds cycle
// - Instruction cycle is four oscillator cycles
// - File operands are read, modified, written back
// - Destination bit clear to accumulator, set file
// - File address selects one of 128 locations
// - Bit index selects one of eight bits
// - Pointer number selects one of two pointers
// - Two-bit mode picks pointer pre/post inc/dec
// - Don't-care bits never change execution
// - Literal field passed to datapath or counter
// - Second cycle of flow change is no-operation
// - Pointer top bit set means program memory
module instr_word_decode_timing (
  input  wire        core_clk,
  input  wire        srst,
  input  wire [13:0] instr_word,
  input  wire        instr_valid,
  output wire        instr_ready,
  input  wire        skip_taken,
  input  wire [1:0]  ptr_top_bit,
  output reg  [1:0]  instr_class,
  output reg  [6:0]  file_addr,
  output reg  [2:0]  bit_index,
  output reg  [10:0] literal,
  output reg         dest_to_file,
  output reg         pointer_sel,
  output reg  [1:0]  pointer_update_mode,
  output reg         pointer_move,
  output reg  [1:0]  cycle_index,
  output reg         nop_cycle,
  output reg         file_read,
  output reg         file_write,
  output wire [1:0]  osc_phase,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire        pready,
  output wire        pslverr
);

  reg  [1:0]  phase_ff;
  reg         busy_ff;
  reg  [1:0]  cyc_ff;
  reg  [1:0]  last_exec_ff;
  reg         flow_ff;
  reg         skip_ff;
  reg         file_op_ff;
  reg         run_ff;
  reg  [31:0] retired_ff;
  reg  [13:0] lastword_ff;

  // Opcode field split
  wire [1:0] top     = instr_word[13:12];
  wire [3:0] mid     = instr_word[11:8];
  wire       grp_zero = (top == 2'h0) && (mid == `OP_ZERO_GRP) &&
                        !instr_word[7];
  // Shift and carry/borrow file ops live in the top opcode group
  wire       is_byte_hi = (top == 2'h3) &&
                          ((mid == 4'h5) || (mid == 4'h6) ||
                           (mid == 4'h7) || (mid == 4'hb) ||
                           (mid == 4'hd));
  wire       is_byte = ((top == 2'h0) && !grp_zero) ||
                       is_byte_hi;
  wire       is_bit  = (top == 2'h1);
  // Low two bits of the accumulator clear are ignored
  wire       is_clrw = (top == 2'h0) &&
                       (instr_word[11:2] == `OP_CLRW_HI);
  wire       is_ptrmv = grp_zero &&
                        (instr_word[7:4] == 4'h1);
  wire       file_op = (is_byte && !is_clrw) || is_bit;
  wire [6:0] f_fld   = instr_word[6:0];
  wire       hit_indirect_file_register = file_op &&
                        ((f_fld == `INDF0_ADDR) || (f_fld == `INDF1_ADDR));
  wire       indirect_file_register_sel = (f_fld == `INDF1_ADDR);
  wire       ind_n    = is_ptrmv ? instr_word[2] : indirect_file_register_sel;
  // Pointer top bit set addresses program memory
  wire       ind_pm  = (hit_indirect_file_register || is_ptrmv) && ptr_top_bit[ind_n];

  // Unconditional flow changes and conditional skips
  wire is_call  = (top == 2'h2) && !instr_word[11];
  wire is_absolute_jump  = (top == 2'h2) && instr_word[11];
  wire is_subroutine_jump_accum = (instr_word == `OP_CALL_ACC);
  wire is_brw   = (instr_word == `OP_BR_ACC);
  wire is_ret   = (instr_word == `OP_RET_SUB) ||
                  (instr_word == `OP_RET_INT);
  wire is_retl  = (top == 2'h3) && (mid == `OP_RET_LIT_HI);
  wire is_bra   = (top == 2'h3) &&
                  (instr_word[11:9] == `OP_BR_REL_HI);
  wire flow     = is_call || is_absolute_jump || is_subroutine_jump_accum || is_brw ||
                  is_ret || is_retl || is_bra;
  wire is_skip  = ((top == 2'h0) && ((mid == `OP_DEC_SKIP_HI) ||
                  (mid == `OP_INC_SKIP_HI))) ||
                  (is_bit && ((instr_word[11:10] == `OP_BIT_CLR_SKIP) ||
                  (instr_word[11:10] == `OP_BIT_SET_SKIP)));

  // Sequencer status at the end of an instruction cycle
  wire cyc_end   = (phase_ff == `PHASE_LAST);
  wire exec_done = (cyc_ff >= last_exec_ff);
  wire nop_due   = !nop_cycle && (flow_ff || (skip_ff && skip_taken));
  wire done_now  = busy_ff && cyc_end && (exec_done && !nop_due);
  wire accept    = instr_valid && instr_ready;

  assign instr_ready = run_ff && cyc_end &&
                       (!busy_ff || (exec_done && !nop_due));
  assign osc_phase = phase_ff;

  // Four oscillator cycles make one instruction cycle
  always @(posedge core_clk) begin
    if (srst) begin
      phase_ff <= 2'h0;
    end else begin
      phase_ff <= phase_ff + 2'h1;
    end
  end

  // Field capture and cycle sequencing
  always @(posedge core_clk) begin
    if (srst) begin
      busy_ff             <= 1'b0;
      cyc_ff              <= 2'h0;
      last_exec_ff        <= 2'h0;
      flow_ff             <= 1'b0;
      skip_ff             <= 1'b0;
      file_op_ff          <= 1'b0;
      nop_cycle           <= 1'b0;
      cycle_index         <= 2'h0;
      instr_class         <= `CLS_BYTE;
      file_addr           <= 7'h00;
      bit_index           <= 3'h0;
      literal             <= 11'h000;
      dest_to_file        <= 1'b1;
      pointer_sel         <= 1'b0;
      pointer_update_mode <= 2'h0;
      pointer_move        <= 1'b0;
      lastword_ff         <= 14'h0000;
    end else if (accept) begin
      busy_ff      <= 1'b1;
      cyc_ff       <= 2'h0;
      cycle_index  <= 2'h0;
      nop_cycle    <= 1'b0;
      // One cycle unless an indirect program memory access adds one
      last_exec_ff <= {1'b0, ind_pm};
      flow_ff      <= flow;
      skip_ff      <= is_skip;
      file_op_ff   <= file_op;
      lastword_ff  <= instr_word;
      instr_class  <= is_byte ? `CLS_BYTE :
                      (is_bit ? `CLS_BIT : `CLS_LIT);
      file_addr    <= f_fld;
      bit_index    <= instr_word[9:7];
      literal      <= instr_word[10:0];
      dest_to_file <= is_byte ? instr_word[7] : 1'b1;
      pointer_sel  <= ind_n;
      pointer_update_mode <= instr_word[1:0];
      pointer_move <= is_ptrmv;
    end else if (busy_ff && cyc_end) begin
      if (done_now) begin
        busy_ff   <= 1'b0;
        nop_cycle <= 1'b0;
      end else begin
        cyc_ff      <= cyc_ff + 2'h1;
        cycle_index <= cyc_ff + 2'h1;
        // Flush cycle after a flow change or a taken skip
        if (exec_done) begin
          nop_cycle <= 1'b1;
        end
      end
    end
  end

  // Read in the first cycle, write back at the end of the last execute cycle
  always @(posedge core_clk) begin
    if (srst) begin
      file_read  <= 1'b0;
      file_write <= 1'b0;
    end else begin
      file_read  <= busy_ff && file_op_ff && !nop_cycle &&
                    (cyc_ff == 2'h0) && (phase_ff == 2'h0);
      file_write <= busy_ff && file_op_ff && !nop_cycle &&
                    exec_done && (phase_ff == 2'h2);
    end
  end

  // APB register file, zero wait states
  wire apb_wr = psel && penable && pwrite;
  wire hit_ctrl = (paddr == `OFS_CTRL);
  wire hit_stat = (paddr == `OFS_STAT);
  wire hit_ret  = (paddr == `OFS_RETIRED);
  wire hit_last = (paddr == `OFS_LASTWORD);
  wire mapped   = hit_ctrl || hit_stat || hit_ret || hit_last;

  always @(posedge core_clk) begin
    if (srst) begin
      run_ff     <= `CTRL_RST_VAL;
      retired_ff <= 32'h0000_0000;
    end else begin
      if (apb_wr && hit_ctrl) begin
        run_ff <= pwdata[`CTRL_RUN_BIT];
      end
      if (apb_wr && hit_ret) begin
        retired_ff <= pwdata;
      end else if (done_now) begin
        retired_ff <= retired_ff + 32'h0000_0001;
      end
    end
  end

  wire [31:0] stat_word = {26'h0, instr_class, nop_cycle,
                           cyc_ff, busy_ff};

  assign prdata  = hit_ctrl ? {31'h0, run_ff} :
                   hit_stat ? stat_word :
                   hit_ret  ? retired_ff :
                   hit_last ? {18'h0, lastword_ff} : 32'h0000_0000;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;

endmodule
`default_nettype wire

/* tb/instr_decode_monitor.sv */
// Assertion checker for the instruction decoder
`timescale 1ns/1ns
`default_nettype none
module decode_chk (
  input wire        core_clk,
  input wire        srst,
  input wire [13:0] instr_word,
  input wire        instr_valid,
  input wire        instr_ready,
  input wire [1:0]  osc_phase,
  input wire [1:0]  cycle_index,
  input wire        nop_cycle,
  input wire        file_read,
  input wire        file_write,
  input wire [6:0]  file_addr,
  input wire [2:0]  bit_index,
  input wire [10:0] literal
);
  default clocking dc @(posedge core_clk); endclocking
  default disable iff (srst);
  reg  [13:0] acc_ff;
  wire        acc = instr_valid & instr_ready;
  always @(posedge core_clk)
    if (acc)
      acc_ff <= instr_word;
  property p_step; !$past(srst) |-> osc_phase == $past(osc_phase) + 2'h1; endproperty
  a_step: assert property (p_step) else $error("phase skipped");
  property p_rdy; instr_ready |-> osc_phase == 2'h3; endproperty
  a_rdy: assert property (p_rdy) else $error("ready off phase");
  property p_fld; acc |=> file_addr == acc_ff[6:0] && bit_index == acc_ff[9:7]; endproperty
  a_fld: assert property (p_fld) else $error("field wrong");
  property p_lit; acc |=> literal == acc_ff[10:0] && cycle_index == 2'h0; endproperty
  a_lit: assert property (p_lit) else $error("literal wrong");
  property p_hold; acc |=> !instr_ready [*3]; endproperty
  a_hold: assert property (p_hold) else $error("cycle too short");
  property p_rd; file_read |-> osc_phase == 2'h1 && cycle_index == 2'h0; endproperty
  a_rd: assert property (p_rd) else $error("read misplaced");
  property p_wr; file_write |-> osc_phase == 2'h3; endproperty
  a_wr: assert property (p_wr) else $error("write misplaced");
  property p_nop; nop_cycle |-> cycle_index != 2'h0 && !file_write; endproperty
  a_nop: assert property (p_nop) else $error("nop misplaced");
  c_nop: cover property (nop_cycle);
  c_three: cover property (cycle_index == 2'h2);
  c_wr: cover property (file_write);
endmodule
bind instr_word_decode_timing decode_chk u_chk (.core_clk, .srst,
  .instr_word, .instr_valid, .instr_ready, .osc_phase, .cycle_index,
  .nop_cycle, .file_read, .file_write, .file_addr, .bit_index, .literal);
`default_nettype wire

/* tb/tb.sv */
// Self-checking bench for the instruction decoder
`timescale 1ns/1ns
`default_nettype none
`include "instr_decode_regs.vh"
module tb;
  logic        core_clk = 1'b0;
  logic        srst = 1'b1;
  logic [13:0] instr_word = 14'h0000;
  logic        instr_valid = 1'b0;
  logic        skip_taken = 1'b0;
  logic [1:0]  ptr_top_bit = 2'h0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] rd;
  logic        err;
  wire         pmove;
  wire         instr_ready, dest_to_file, pointer_sel, nop_cycle, pready;
  wire         pslverr;
  wire [1:0]   instr_class, pointer_update_mode;
  wire [6:0]   file_addr;
  wire [2:0]   bit_index;
  wire [10:0]  literal;
  wire [31:0]  prdata;
  int          fails = 0;
  int          n_compared = 0;
  instr_word_decode_timing dut (.core_clk, .srst, .instr_word,
    .instr_valid, .instr_ready, .skip_taken, .ptr_top_bit, .instr_class,
    .file_addr, .bit_index, .literal, .dest_to_file, .pointer_sel,
    .pointer_update_mode, .pointer_move(pmove), .cycle_index(), .nop_cycle,
    .file_read(), .file_write(), .osc_phase(), .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr);
  always #50 core_clk = ~core_clk;
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
    n_compared++;
    if (seen !== ex) begin
      fails++;
      $display("[ERR] %s exp %h seen %h", nm, ex, seen);
    end
  endtask
  task end_sim;
    if (fails == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1)
      @(posedge core_clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Offer one word, then count negedges until ready returns
  task issue(input logic [13:0] w, input logic [1:0] tp, input logic sk,
             input int n, input int np);
    int k;
    int nops;
    nops = 0;
    @(posedge core_clk);
    instr_word <= w;
    instr_valid <= 1'b1;
    ptr_top_bit <= tp;
    skip_taken <= sk;
    do @(negedge core_clk); while (instr_ready !== 1'b1);
    @(posedge core_clk);
    instr_valid <= 1'b0;
    @(negedge core_clk);
    chk("addr", file_addr, w[6:0]);
    chk("bit", bit_index, w[9:7]);
    chk("lit", literal, w[10:0]);
    for (k = 1; instr_ready !== 1'b1 && k < 20; k++) begin
      @(negedge core_clk);
      nops += (nop_cycle === 1'b1);
    end
    chk("cycles", k, 4 * n);
    chk("nops", nops, 4 * np);
  endtask
  task t_classes;
    issue(14'h07d5, 2'h0, 1'b0, 1, 0);
    chk("dest", dest_to_file, 1'b1);
    issue(14'h0755, 2'h0, 1'b0, 1, 0);
    chk("dest", dest_to_file, 1'b0);
    chk("class", instr_class, `CLS_BYTE);
    issue(14'h3d55, 2'h0, 1'b0, 1, 0);
    chk("class", instr_class, `CLS_BYTE);
    chk("dest", dest_to_file, 1'b0);
    issue(14'h12aa, 2'h0, 1'b0, 1, 0);
    chk("class", instr_class, `CLS_BIT);
    issue(14'h30a5, 2'h0, 1'b0, 1, 0);
    chk("class", instr_class, `CLS_LIT);
  endtask
  task t_flow;
    logic [13:0] ops [8] = '{14'h2123, 14'h000a, 14'h0008, 14'h3455,
                             14'h0009, 14'h2923, 14'h3277, 14'h000b};
    foreach (ops[i])
      issue(ops[i], 2'h0, 1'b0, 2, 1);
  endtask
  task t_skip;
    issue(14'h0b40, 2'h0, 1'b0, 1, 0);
    issue(14'h0b40, 2'h0, 1'b1, 2, 1);
    issue(14'h0f40, 2'h0, 1'b1, 2, 1);
    issue(14'h1f40, 2'h0, 1'b1, 2, 1);
    issue(14'h1b40, 2'h0, 1'b0, 1, 0);
  endtask
  task t_indirect;
    issue(14'h0780, 2'h1, 1'b0, 2, 0);
    issue(14'h0780, 2'h2, 1'b0, 1, 0);
    issue(14'h0781, 2'h2, 1'b0, 2, 0);
    issue(14'h0b80, 2'h1, 1'b1, 3, 1);
  endtask
  task t_modes;
    for (int m = 0; m < 4; m++) begin
      issue(14'h0014 | 14'(m), 2'h0, 1'b0, 1, 0);
      chk("mode", pointer_update_mode, m[1:0]);
      chk("psel", pointer_sel, 1'b1);
      chk("pmove", pmove, 1'b1);
      issue(14'h0100 | 14'(m), 2'h0, 1'b0, 1, 0);
      chk("class", instr_class, `CLS_BYTE);
    end
  endtask
  task t_apb;
    apb(1'b0, `OFS_CTRL, 32'h0);
    chk("ctrl", rd, `CTRL_RST_VAL);
    apb(1'b1, `OFS_RETIRED, 32'h10);
    issue(14'h30a5, 2'h0, 1'b0, 1, 0);
    apb(1'b0, `OFS_RETIRED, 32'h0);
    chk("retired", rd, 32'h11);
    apb(1'b0, `OFS_LASTWORD, 32'h0);
    chk("last", rd, 32'h30a5);
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped", {rd[30:0], err}, 32'h1);
    apb(1'b1, `OFS_CTRL, 32'h0);
    repeat (8) @(negedge core_clk) chk("stopped", instr_ready, 1'b0);
    apb(1'b1, `OFS_CTRL, 32'h1);
  endtask
  initial begin
    repeat (8) @(posedge core_clk);
    srst <= 1'b0;
    t_classes;
    t_flow;
    t_skip;
    t_indirect;
    t_modes;
    t_apb;
    end_sim;
  end
  initial begin
    #1000000;
    fails++;
    end_sim;
  end
endmodule
`default_nettype wire
